// File: design/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_OFS_CTRL 12'h000
`define WDT_OFS_RELOAD 12'h004
`define WDT_OFS_WINDOW 12'h008
`define WDT_OFS_SERVICE 12'h00c
`define WDT_OFS_STATUS 12'h010
`define WDT_OFS_COUNT 12'h014

`define WDT_CTRL_EN 0
`define WDT_CTRL_SLOW 1
`define WDT_CTRL_DBG_RUN 2

`define WDT_SERVICE_KEY 8'ha5
`define WDT_CTRL_RST 3'h0
`define WDT_RELOAD_RST 8'h00
`define WDT_WINDOW_RST 8'h00

`define WDT_DIV_FAST 7'h01
`define WDT_DIV_SLOW 7'h7f
// prewarning lasts this long before the system reset is asserted
`define WDT_PREWARN_NS 12800
`define WDT_CLK_NS 50
`define WDT_PREWARN_CYC (`WDT_PREWARN_NS / `WDT_CLK_NS)
`endif

// File: design/wdt_pkg.sv
package wdt_pkg;
  typedef enum logic [2:0] {
    WDT_RUN = 3'b001,
    WDT_WARN = 3'b010,
    WDT_RESET = 3'b100
  } wdt_state_type;
endpackage : wdt_pkg

// File: design/wdt_stage.sv
module wdt_stage (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic inc,
  input wire logic load,
  input wire logic [7:0] load_val,
  output logic [7:0] cnt_q,
  output logic carry
);
  assign carry = inc && (cnt_q == 8'hff);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (inc) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : wdt_stage

// File: design/wdt_top.sv
// Implementation choices: the placing of the registers and register access over APB.
`include "wdt_cfg.svh"

module wdt_top
  import wdt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_mode,
  output logic nmi,
  output logic prewarn,
  output logic sys_reset
);
  logic [2:0] ctrl_q;
  logic [7:0] reload_q;
  logic [7:0] window_q;
  logic [6:0] div_q;
  logic [1:0] dbg_sync_q;
  logic [31:0] prdata_q;
  logic [15:0] warn_cnt_q;
  logic timeout_q;
  logic early_q;
  wdt_state_type state_q;
  logic wr, rd, service, tick, low_carry, hi_carry, counting, timeout_ev;
  logic [7:0] low_cnt, high_cnt;
  logic [6:0] div_max;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign service = wr && (paddr == `WDT_OFS_SERVICE) && (pwdata[7:0] == `WDT_SERVICE_KEY);

  // unmapped addresses answer with an error; nothing is stored
  always_comb begin
    if (!(psel && penable)) begin
      pslverr = 1'b0;
    end else if (paddr == `WDT_OFS_CTRL || paddr == `WDT_OFS_RELOAD || paddr == `WDT_OFS_WINDOW) begin
      pslverr = 1'b0;
    end else if (paddr == `WDT_OFS_SERVICE || paddr == `WDT_OFS_STATUS || paddr == `WDT_OFS_COUNT) begin
      pslverr = 1'b0;
    end else begin
      pslverr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `WDT_CTRL_RST;
      reload_q <= `WDT_RELOAD_RST;
      window_q <= `WDT_WINDOW_RST;
    end else if (wr) begin
      if (paddr == `WDT_OFS_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end else if (paddr == `WDT_OFS_RELOAD) begin
        reload_q <= pwdata[7:0];
      end else if (paddr == `WDT_OFS_WINDOW) begin
        window_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `WDT_OFS_CTRL) begin
        prdata_q <= {29'h0, ctrl_q};
      end else if (paddr == `WDT_OFS_RELOAD) begin
        prdata_q <= {24'h0, reload_q};
      end else if (paddr == `WDT_OFS_WINDOW) begin
        prdata_q <= {24'h0, window_q};
      end else if (paddr == `WDT_OFS_STATUS) begin
        prdata_q <= {27'h0, state_q, early_q, timeout_q};
      end else if (paddr == `WDT_OFS_COUNT) begin
        prdata_q <= {16'h0, high_cnt, low_cnt};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // debug level comes from the cpu's debug logic, so it is synchronised
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dbg_sync_q <= 2'b00;
    end else begin
      dbg_sync_q <= {dbg_sync_q[0], debug_mode};
    end
  end

  assign counting = ctrl_q[`WDT_CTRL_EN] && (state_q == WDT_RUN)
                    && !(dbg_sync_q[1] && !ctrl_q[`WDT_CTRL_DBG_RUN]);
  assign div_max = ctrl_q[`WDT_CTRL_SLOW] ? `WDT_DIV_SLOW : `WDT_DIV_FAST;
  assign tick = counting && (div_q >= div_max);

  // prescaler restarts on service so each interval starts from a clean edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 7'h00;
    end else if (service || tick) begin
      div_q <= 7'h00;
    end else if (counting) begin
      div_q <= div_q + 7'h01;
    end
  end

  wdt_stage u_low (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inc(tick),
    .load(service),
    .load_val(8'h00),
    .cnt_q(low_cnt),
    .carry(low_carry)
  );

  wdt_stage u_high (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .inc(low_carry),
    .load(service),
    .load_val(reload_q),
    .cnt_q(high_cnt),
    .carry(hi_carry)
  );

  // early service inside an enabled run is treated like an expiry, except that early_q is set in the status
  assign timeout_ev = (state_q == WDT_RUN) && ctrl_q[`WDT_CTRL_EN]
                      && (hi_carry || (service && (high_cnt < window_q)));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timeout_q <= 1'b0;
      early_q <= 1'b0;
    end else if (timeout_ev) begin
      timeout_q <= 1'b1;
      early_q <= !hi_carry;
    end
  end

  // once expired, software cannot stop the reset: only nrst ends it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= WDT_RUN;
      warn_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        WDT_RUN: begin
          warn_cnt_q <= 16'h0000;
          if (timeout_ev) begin
            state_q <= WDT_WARN;
          end
        end
        WDT_WARN: begin
          warn_cnt_q <= warn_cnt_q + 16'h0001;
          if (warn_cnt_q == 16'(`WDT_PREWARN_CYC - 1)) begin
            state_q <= WDT_RESET;
          end
        end
        WDT_RESET: begin
          state_q <= WDT_RESET;
        end
        default: begin
          state_q <= WDT_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nmi <= 1'b0;
      prewarn <= 1'b0;
      sys_reset <= 1'b0;
    end else begin
      nmi <= (state_q == WDT_RUN) ? timeout_ev : nmi;
      prewarn <= timeout_ev || (state_q != WDT_RUN);
      sys_reset <= (state_q == WDT_RESET);
    end
  end
endmodule : wdt_top

// File: bench/wdt_monitor.sv
module wdt_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic nmi,
  input wire logic prewarn,
  input wire logic sys_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic acc;
  assign acc = psel && penable;
  property p_nmi; nmi |-> prewarn; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without prewarn");
  property p_hold; prewarn |=> prewarn && nmi; endproperty
  a_hold: assert property (p_hold) else $error("warning dropped");
  property p_warn; $rose(prewarn) |-> !sys_reset [*8]; endproperty
  a_warn: assert property (p_warn) else $error("reset without warning time");
  property p_sr; sys_reset |-> prewarn; endproperty
  a_sr: assert property (p_sr) else $error("reset without prewarn");
  property p_pair; $rose(nmi) |-> $rose(prewarn); endproperty
  a_pair: assert property (p_pair) else $error("nmi and prewarn apart");
  property p_cnt; acc && paddr == 12'h014 |-> prdata[31:16] == 16'h0000; endproperty
  a_cnt: assert property (p_cnt) else $error("count wider than 16 bits");
  property p_err; acc && paddr > 12'h014 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok; acc && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  cover property ($rose(sys_reset));
  cover property ($rose(nmi));
  cover property (acc && pslverr);
endmodule : wdt_monitor

bind wdt_top wdt_monitor mon (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pslverr(pslverr), .nmi(nmi), .prewarn(prewarn), .sys_reset(sys_reset));

// File: bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, debug_mode = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, x;
  logic pready, pslverr, nmi, prewarn, sys_reset, err;
  int errors = 0, samples_checked = 0;
  logic [11:0] ra [4] = '{12'h000, 12'h004, 12'h008, 12'h00c};
  // the table leaves the watchdog disabled, so the keyed service row cannot trip the window check
  logic [31:0] rw [4] = '{32'h6, 32'h1ff, 32'h1a5, 32'ha5};
  logic [31:0] rx [4] = '{32'h6, 32'hff, 32'ha5, 32'h0};
  always #25 ref_clk = ~ref_clk;
  wdt_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .debug_mode(debug_mode), .nmi(nmi),
    .prewarn(prewarn), .sys_reset(sys_reset));
  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask : chk
  // a wait that runs out of cycles ends the run as a failure
  task automatic wt(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'b1; k++) @(posedge ref_clk);
    if (s !== 1'b1) begin
      errors++;
      end_of_test();
    end
  endtask : wt
  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
    psel <= 1'b1;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    wt(pready, 8);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      apb(ra[j], 0, 0);
      chk(rd, 0);
    end
    foreach (ra[j]) begin
      apb(ra[j], rw[j], 1);
      apb(ra[j], 0, 0);
      chk(rd, rx[j]);
    end
    apb(12'h000, 1, 1);
    apb(12'h004, 32'hfe, 1);
    apb(12'h00c, 32'ha5, 1);
    apb(12'h014, 0, 0);
    chk(rd[15:8], 8'hfe);
    chk(rd[7:0] < 8'h04, 1);
    debug_mode <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(12'h014, 0, 0);
    x = rd;
    repeat (20) @(posedge ref_clk);
    apb(12'h014, 0, 0);
    chk(rd, x);
    debug_mode <= 1'b0;
    // slow rate gives two ticks in 256 cycles where the fast one gives 128
    apb(12'h000, 3, 1);
    apb(12'h00c, 32'ha5, 1);
    repeat (256) @(posedge ref_clk);
    apb(12'h014, 0, 0);
    chk(rd[7:0] < 8'h04, 1);
    apb(12'h000, 1, 1);
    apb(12'h00c, 32'ha5, 1);
    chk(nmi, 0);
    wt(nmi, 1200);
    chk(prewarn, 1);
    chk(sys_reset, 0);
    wt(sys_reset, 300);
    apb(12'h010, 0, 0);
    chk(rd, 32'h11);
    apb(12'h018, 32'h5, 0);
    chk(err, 1);
    chk(rd, 0);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk({nmi, prewarn, sys_reset}, 0);
    apb(12'h008, 32'h80, 1);
    apb(12'h000, 1, 1);
    apb(12'h00c, 32'ha5, 1);
    wt(nmi, 4);
    apb(12'h010, 0, 0);
    chk(rd, 32'h0b);
    end_of_test();
  end
endmodule : tb_top
